// [src/alarm_input_conditioner.sv]
// configurable conditioning of eight discrete alarm inputs
// Behaviour
// - action 0 fault commands immediate stop
// - action 1 fault requests stop after cooldown
// - action 2 horn only; action 3 nothing
// - sampling 0 always; 1 after holdoff
// - sampling 2 only while mains present
// - latching bit holds fault after release
// - contact 0 closed faults; 1 open faults
// - delay 1 needs fault held four seconds
// - oil pressure input reset configuration
// - force to start input reset configuration
// - low fuel input reset configuration
// - eight independently configured inputs
`timescale 1ns/1ps
module alarm_input_conditioner #(
	parameter int RESP_DELAY_CYCLES = alarm_input_pkg::RESP_DELAY_CYC
)(
	input  wire logic        MCLK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic [7:0]  CONTACT_CLOSED_I,
	input  wire logic        HOLDOFF_DONE_I,
	input  wire logic        MAINS_PRESENT_I,
	input  wire logic        ALARM_RESET_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	output logic             STOP_NOW_O,
	output logic             STOP_COOLDOWN_O,
	output logic             HORN_O,
	output logic      [7:0]  FAULT_O,
	output logic             IRQ_O
);

	localparam int N = alarm_input_pkg::NUM_INPUTS;

	// last count of the persistence timer; a bench may shorten the delay through the parameter
	localparam int            DW       = alarm_input_pkg::DLY_W;
	localparam logic [DW-1:0] DLY_LAST = DW'(RESP_DELAY_CYCLES - 1);

	// reset configuration table, one word per input
	// word layout is {delay,switching,contact,latch,sampling[1:0],action[1:0]}
	// the switching bit is only stored; battery polarity is handled in the front end
	localparam logic [7:0] CFG_RST [N] = '{
		alarm_input_pkg::CFG_RST_HIGH_TEMP,
		alarm_input_pkg::CFG_RST_OIL_PRESS,
		alarm_input_pkg::CFG_RST_EMERG_STOP,
		alarm_input_pkg::CFG_RST_FORCE_RUN,
		alarm_input_pkg::CFG_RST_LOW_FUEL,
		alarm_input_pkg::CFG_RST_SPARE1,
		alarm_input_pkg::CFG_RST_SPARE2,
		alarm_input_pkg::CFG_RST_COOLANT
	};

	logic [7:0]  cfg_reg [N];
	logic [7:0]  sync1_reg;
	logic [7:0]  sync2_reg;
	logic [7:0]  sync3_reg;
	logic [7:0]  contact_reg;
	logic [2:0]  ho_sync_reg;
	logic [2:0]  mains_sync_reg;
	logic [2:0]  arst_sync_reg;
	logic        holdoff_reg;
	logic        mains_reg;
	logic        arst_reg;
	logic [alarm_input_pkg::DLY_W-1:0] dly_cnt_reg [N];
	logic [7:0]  fault_reg;
	logic [7:0]  status_reg;
	logic [7:0]  mask_reg;
	logic [7:0]  rdata_reg;
	logic        stop_now_reg;
	logic        stop_cd_reg;
	logic        horn_reg;
	logic        irq_reg;

	wire  [7:0]  raw_fault;
	wire  [7:0]  qualified;
	wire  [7:0]  confirmed;
	wire  [7:0]  fault_next;
	wire  [7:0]  rise;
	wire  [7:0]  status_next;
	wire         rd_status;
	wire         cfg_sel;
	wire  [7:0]  rd_mux;
	wire  [7:0]  contact_agree;
	wire  [7:0]  contact_next;
	wire  [7:0]  act_stop;
	wire  [7:0]  act_cool;
	wire  [7:0]  act_horn;
	wire  [7:0]  rdata_next;
	wire         stop_now_next;
	wire         stop_cd_next;
	wire         horn_next;
	wire         irq_next;

	// extract a two-bit code from a configuration word
	function automatic logic [1:0] code_of(input logic [7:0] cfg, input int lo);
		code_of = cfg[lo +: 2];
	endfunction

	// contact synchronisers; three stages because the switches sit outside the clock domain
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			sync3_reg <= 8'h00;
		end
		else
		begin
			sync1_reg <= CONTACT_CLOSED_I;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// holdoff, mains and alarm reset levels take the same three-stage path
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			ho_sync_reg    <= 3'h0;
			mains_sync_reg <= 3'h0;
			arst_sync_reg  <= 3'h0;
		end
		else
		begin
			ho_sync_reg    <= {ho_sync_reg[1:0], HOLDOFF_DONE_I};
			mains_sync_reg <= {mains_sync_reg[1:0], MAINS_PRESENT_I};
			arst_sync_reg  <= {arst_sync_reg[1:0], ALARM_RESET_I};
		end
	end

	// a contact bit may move only where stages two and three agree, hiding a metastable sample
	assign contact_agree = ~(sync2_reg ^ sync3_reg);
	assign contact_next  = (sync2_reg & contact_agree) | (contact_reg & ~contact_agree);

	// filtered contact levels; costs one extra cycle of latency on every input
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			contact_reg <= 8'h00;
		else
			contact_reg <= contact_next;
	end

	// filtered control levels; a one-cycle glitch on a pin never reaches the channels
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			holdoff_reg <= 1'b0;
			mains_reg   <= 1'b0;
			arst_reg    <= 1'b0;
		end
		else
		begin
			if (ho_sync_reg[1] == ho_sync_reg[2])
				holdoff_reg <= ho_sync_reg[2];
			if (mains_sync_reg[1] == mains_sync_reg[2])
				mains_reg <= mains_sync_reg[2];
			if (arst_sync_reg[1] == arst_sync_reg[2])
				arst_reg <= arst_sync_reg[2];
		end
	end

	// per-input qualification, eight identical channels
	generate
		for (genvar i = 0; i < N; i++)
		begin : g_ch
			wire [1:0] samp = code_of(cfg_reg[i], alarm_input_pkg::FLD_SAMP_LO);
			wire [1:0] act  = code_of(cfg_reg[i], alarm_input_pkg::FLD_ACT_LO);
			// contact type 0 faults on closed, type 1 faults on open
			assign raw_fault[i] = contact_reg[i] ^ cfg_reg[i][alarm_input_pkg::FLD_CONTACT];
			// one-hot action decode per channel feeds the shared output reductions
			assign act_stop[i] = (act == alarm_input_pkg::ACT_SHUTDOWN);
			assign act_cool[i] = (act == alarm_input_pkg::ACT_LOADDUMP);
			assign act_horn[i] = (act == alarm_input_pkg::ACT_WARNING);
			// sampling window; unused code 3 treated as never sampled
			assign qualified[i] = raw_fault[i] && (act != alarm_input_pkg::ACT_NONE) &&
				((samp == alarm_input_pkg::SAMP_ALWAYS) ||
				 (samp == alarm_input_pkg::SAMP_HOLDOFF && holdoff_reg) ||
				 (samp == alarm_input_pkg::SAMP_MAINS && mains_reg));
			// delayed inputs need an unbroken run of qualified samples
			assign confirmed[i] = qualified[i] && (!cfg_reg[i][alarm_input_pkg::FLD_DELAY] ||
				(dly_cnt_reg[i] >= DLY_LAST));
			// latched faults hold until alarm reset with the input released
			assign fault_next[i] = confirmed[i] || (fault_reg[i] && cfg_reg[i][alarm_input_pkg::FLD_LATCH] &&
				!(arst_reg && !raw_fault[i]));

			// persistence counter restarts whenever the fault drops out
			always_ff @(posedge MCLK_I or posedge SYS_RST_I)
			begin
				if (SYS_RST_I)
					dly_cnt_reg[i] <= '0;
				else if (!qualified[i])
					dly_cnt_reg[i] <= '0;
				else if (dly_cnt_reg[i] < DLY_LAST)
					dly_cnt_reg[i] <= dly_cnt_reg[i] + 1'b1;
			end
		end
	endgenerate

	// register decode
	assign cfg_sel   = (ADDR_I[3] == 1'b0);
	assign rd_status = RD_I && (ADDR_I == alarm_input_pkg::OFF_STATUS);
	assign rd_mux    = cfg_sel ? cfg_reg[ADDR_I[2:0]] :
	                   (ADDR_I == alarm_input_pkg::OFF_STATUS) ? status_reg :
	                   (ADDR_I == alarm_input_pkg::OFF_MASK)   ? mask_reg :
	                   (ADDR_I == alarm_input_pkg::OFF_FAULT)  ? fault_reg : 8'h00;

	// new fault edges set status; a set in the same cycle as the read wins
	assign rise        = fault_next & ~fault_reg;
	assign status_next = (rd_status ? 8'h00 : status_reg) | rise;

	// configuration and mask registers, reset to factory values
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			for (int k = 0; k < N; k++)
				cfg_reg[k] <= CFG_RST[k];
			mask_reg <= alarm_input_pkg::MASK_RST;
		end
		else if (WR_I)
		begin
			if (cfg_sel)
				cfg_reg[ADDR_I[2:0]] <= WDATA_I;
			else if (ADDR_I == alarm_input_pkg::OFF_MASK)
				mask_reg <= WDATA_I;
		end
	end

	// action outputs are decoded from the next fault vector so they line up with the fault port
	assign stop_now_next = |(fault_next & act_stop);
	assign stop_cd_next  = |(fault_next & act_cool);
	assign horn_next     = |(fault_next & act_horn);
	assign irq_next      = |(status_next & mask_reg);
	// unanswered cycles return zero so a stale word is never mistaken for a reply
	assign rdata_next    = RD_I ? rd_mux : 8'h00;

	// fault state and sticky status
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			fault_reg  <= 8'h00;
			status_reg <= 8'h00;
		end
		else
		begin
			fault_reg  <= fault_next;
			status_reg <= status_next;
		end
	end

	// read data register; a reply stands for exactly one cycle
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	// action outputs, registered so every top-level output leaves a flip-flop
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			stop_now_reg <= 1'b0;
			stop_cd_reg  <= 1'b0;
			horn_reg     <= 1'b0;
		end
		else
		begin
			stop_now_reg <= stop_now_next;
			stop_cd_reg  <= stop_cd_next;
			horn_reg     <= horn_next;
		end
	end

	// level interrupt; drops in the same cycle that the status read clears the last bit
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_next;
	end

	// ports are plain copies of registers, so nothing combinational reaches a pin
	assign RDATA_O         = rdata_reg;
	assign STOP_NOW_O      = stop_now_reg;
	assign STOP_COOLDOWN_O = stop_cd_reg;
	assign HORN_O          = horn_reg;
	assign FAULT_O         = fault_reg;
	assign IRQ_O           = irq_reg;

endmodule

// [src/alarm_input_pkg.sv]
// constants and types shared by the alarm input conditioner
package alarm_input_pkg;

	localparam int NUM_INPUTS = 8;
	localparam int CFG_W      = 8;
	localparam int ADDR_W     = 4;

	// configuration word field positions
	localparam int FLD_ACT_LO  = 0;
	localparam int FLD_SAMP_LO = 2;
	localparam int FLD_LATCH   = 4;
	localparam int FLD_CONTACT = 5;
	localparam int FLD_SWITCH  = 6;
	localparam int FLD_DELAY   = 7;

	// action codes
	localparam logic [1:0] ACT_SHUTDOWN = 2'h0;
	localparam logic [1:0] ACT_LOADDUMP = 2'h1;
	localparam logic [1:0] ACT_WARNING  = 2'h2;
	localparam logic [1:0] ACT_NONE     = 2'h3;

	// sampling codes
	localparam logic [1:0] SAMP_ALWAYS  = 2'h0;
	localparam logic [1:0] SAMP_HOLDOFF = 2'h1;
	localparam logic [1:0] SAMP_MAINS   = 2'h2;

	// register offsets: 0..7 per-input configuration, then status, mask, fault state
	localparam logic [3:0] OFF_CFG0   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_MASK   = 4'h9;
	localparam logic [3:0] OFF_FAULT  = 4'hA;
	localparam logic [3:0] OFF_CLEAR  = 4'hB;

	// reset values per input: {delay,switch,contact,latch,samp[1:0],act[1:0]}
	localparam logic [7:0] CFG_RST_HIGH_TEMP  = 8'h14;
	localparam logic [7:0] CFG_RST_OIL_PRESS  = 8'h14;
	localparam logic [7:0] CFG_RST_EMERG_STOP = 8'h00;
	localparam logic [7:0] CFG_RST_FORCE_RUN  = 8'h03;
	localparam logic [7:0] CFG_RST_LOW_FUEL   = 8'h90;
	localparam logic [7:0] CFG_RST_SPARE1     = 8'h02;
	localparam logic [7:0] CFG_RST_SPARE2     = 8'h02;
	localparam logic [7:0] CFG_RST_COOLANT    = 8'h33;
	localparam logic [7:0] MASK_RST           = 8'h00;

	// response delay
	localparam int  CLK_HZ        = 10_000_000;
	localparam int  RESP_DELAY_S  = 4;
	localparam int  RESP_DELAY_CYC = RESP_DELAY_S * CLK_HZ;
	localparam int  DLY_W         = 26;

endpackage

// [verification/alarm_input_properties.sv]
// port-level assertions for the alarm input conditioner
`timescale 1ns/1ps
module alarm_input_properties (
	input wire logic       MCLK_I,
	input wire logic       SYS_RST_I,
	input wire logic [7:0] CONTACT_CLOSED_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       STOP_NOW_O,
	input wire logic       STOP_COOLDOWN_O,
	input wire logic       HORN_O,
	input wire logic [7:0] FAULT_O,
	input wire logic       IRQ_O
);
	logic [7:0] cfg2_reg;
	logic [7:0] mask_reg;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);
	// shadow of the third input's settings, rebuilt from bus writes
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
		if (SYS_RST_I)
			cfg2_reg <= 8'h00;
		else if (WR_I && ADDR_I == 4'h2)
			cfg2_reg <= WDATA_I;
	// shadow of the interrupt mask
	always_ff @(posedge MCLK_I or posedge SYS_RST_I)
		if (SYS_RST_I)
			mask_reg <= 8'h00;
		else if (WR_I && ADDR_I == 4'h9)
			mask_reg <= WDATA_I;
	chk_stop_has_fault: assert property (STOP_NOW_O |-> FAULT_O != 8'h00)
		else $error("stop without fault");
	chk_cool_has_fault: assert property (STOP_COOLDOWN_O |-> FAULT_O != 8'h00)
		else $error("cooldown stop without fault");
	chk_horn_has_fault: assert property (HORN_O |-> FAULT_O != 8'h00)
		else $error("horn without fault");
	chk_none_never_faults: assert property ($rose(FAULT_O[2]) |-> $past(cfg2_reg[1:0]) != 2'h3)
		else $error("fault on ignored input");
	chk_quiet_clears: assert property ((CONTACT_CLOSED_I[2] == cfg2_reg[5] && !cfg2_reg[4]) [*8] |-> !FAULT_O[2])
		else $error("released input still faulted");
	chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data outside answer cycle");
	chk_cfg_readback: assert property ($past(RD_I) && $past(ADDR_I) == 4'h2 |-> RDATA_O == $past(cfg2_reg))
		else $error("settings read back wrong");
	chk_irq_masked: assert property (IRQ_O |-> $past(mask_reg) != 8'h00)
		else $error("interrupt while fully masked");
	cover property ($rose(STOP_NOW_O));
	cover property ($rose(STOP_COOLDOWN_O));
	cover property ($rose(HORN_O));
endmodule
bind alarm_input_conditioner alarm_input_properties u_props (.*);

// [verification/plant_contacts.sv]
// engine and plant switch contacts wired to the alarm inputs
`timescale 1ns/1ps
module plant_contacts (
	input  wire logic       clk_i,
	input  wire logic [7:0] close_i,
	output logic      [7:0] closed_o
);
	// contacts move on a clock edge; bounce is left out to keep runs short
	always @(posedge clk_i)
		closed_o <= close_i;
endmodule

// [verification/test_alarm_input_conditioner.sv]
// self-checking bench for the alarm input conditioner
`timescale 1ns/1ps
module test_alarm_input_conditioner;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] close = 8'h00;
	logic [7:0] contacts;
	logic       holdoff = 1'b0;
	logic       mains = 1'b0;
	logic       alarm_rst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       stop_now, stop_cool, horn, irq;
	logic [7:0] fault;
	int         miscompares = 0;
	int         compares = 0;
	logic [7:0] rst_tab [8] = '{8'h14, 8'h14, 8'h00, 8'h03, 8'h90, 8'h02, 8'h02, 8'h33};
	plant_contacts u_plant (.clk_i(clk), .close_i(close), .closed_o(contacts));
	// short response delay so the delayed input resolves in a few dozen cycles
	alarm_input_conditioner #(.RESP_DELAY_CYCLES(20)) u_dut (
		.MCLK_I(clk), .SYS_RST_I(rst), .CONTACT_CLOSED_I(contacts), .HOLDOFF_DONE_I(holdoff),
		.MAINS_PRESENT_I(mains), .ALARM_RESET_I(alarm_rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STOP_NOW_O(stop_now), .STOP_COOLDOWN_O(stop_cool),
		.HORN_O(horn), .FAULT_O(fault), .IRQ_O(irq));
	initial
		forever #50 clk = ~clk;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data is looked at mid-cycle, after the answering edge has landed
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp(rdata, exp);
	endtask
	task automatic outs(input logic [2:0] e, input logic [7:0] f);
		@(negedge clk);
		cmp({5'h00, stop_now, stop_cool, horn}, {5'h00, e});
		cmp(fault, f);
		@(posedge clk);
	endtask
	task automatic wrap_up;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#500_000;
		miscompares++;
		wrap_up;
	end
	initial
	begin
		cyc(6);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rd_reg(i[3:0], rst_tab[i]);
		rd_reg(4'hC, 8'h00);
		wr_reg(4'h9, 8'h04);
		// every action code on the third input, contact closed then opened
		for (int a = 0; a < 4; a++)
		begin
			wr_reg(4'h2, a[7:0]);
			close <= 8'h04;
			cyc(10);
			outs(3'b100 >> a, {5'h00, a != 3, 2'h0});
			close <= 8'h00;
			cyc(10);
		end
		@(negedge clk);
		cmp({7'h00, irq}, 8'h01);
		rd_reg(4'h8, 8'h04);
		cyc(2);
		outs(3'b000, 8'h00);
		cmp({7'h00, irq}, 8'h00);
		wr_reg(4'h2, 8'h20);
		cyc(10);
		outs(3'b100, 8'h04);
		wr_reg(4'h2, 8'h08);
		close <= 8'h04;
		cyc(10);
		outs(3'b000, 8'h00);
		mains <= 1'b1;
		cyc(10);
		outs(3'b100, 8'h04);
		close <= 8'h02;
		mains <= 1'b0;
		cyc(10);
		outs(3'b000, 8'h00);
		holdoff <= 1'b1;
		cyc(10);
		outs(3'b100, 8'h02);
		close <= 8'h00;
		cyc(10);
		outs(3'b100, 8'h02);
		rd_reg(4'hA, 8'h02);
		alarm_rst <= 1'b1;
		cyc(10);
		outs(3'b000, 8'h00);
		alarm_rst <= 1'b0;
		close     <= 8'h10;
		cyc(10);
		outs(3'b000, 8'h00);
		cyc(20);
		outs(3'b100, 8'h10);
		// a second reset in mid-run must restore factory settings and drop latched faults
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		rd_reg(4'h2, 8'h00);
		outs(3'b000, 8'h00);
		wrap_up;
	end
endmodule
